// >>> design/timer_pkg.sv
// constants shared by the dual timer control block
// assumes an 8-bit register port with a 3-bit register index
package timer_pkg;
  // register indices on the plain register port
  localparam logic [2:0] IDX_MODE     = 3'h0;
  localparam logic [2:0] IDX_FLAGS    = 3'h1;
  localparam logic [2:0] IDX_UPPER    = 3'h2;
  localparam logic [2:0] IDX_LOWER    = 3'h3;
  localparam logic [2:0] IDX_UPPER_CMP = 3'h4;
  localparam logic [2:0] IDX_LOWER_CMP = 3'h5;
  // mode register fields
  localparam int HIGH_LEVEL_BIT = 7;
  localparam int HIGH_SEL_MSB   = 6;
  localparam int HIGH_SEL_LSB   = 4;
  localparam int LOW_LEVEL_BIT  = 3;
  localparam int LOW_SEL_MSB    = 2;
  localparam int LOW_SEL_LSB    = 0;
  // flags register fields
  localparam int HIGH_OVF_BIT   = 7;
  localparam int HIGH_MATCH_BIT = 6;
  localparam int HIGH_OVIE_BIT  = 5;
  localparam int HIGH_CLR_BIT   = 4;
  localparam int LOW_OVF_BIT    = 3;
  localparam int LOW_MATCH_BIT  = 2;
  localparam int LOW_OVIE_BIT   = 1;
  localparam int LOW_CLR_BIT    = 0;
  localparam logic [7:0] FLAG_MASK = 8'hcc;
  // reset values
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET   = 8'hff;
  // clock source codes
  localparam logic [2:0] SEL_DIV32  = 3'h4;
  localparam logic [2:0] SEL_DIV16  = 3'h5;
  localparam logic [2:0] SEL_DIV4   = 3'h6;
  localparam logic [2:0] SEL_WDIV4  = 3'h7;
  // divider ratios
  localparam int SYS_DIV_MAX   = 32;
  localparam int WATCH_DIV     = 4;
endpackage : timer_pkg

// >>> design/tick_if.sv
// count enable pulses from the prescaler to the timer core
// assumes all pulses are one system clock long
interface tick_if;
  logic div32;
  logic div16;
  logic div4;
  logic wdiv4;
  modport src (output div32, output div16, output div4, output wdiv4);
  modport dst (input div32, input div16, input div4, input wdiv4);
endinterface : tick_if

// >>> design/tick_source.sv
// prescaler: system clock divided by 32, 16 and 4, watch clock divided by 4
// assumes the watch clock level is synchronous to sys_clk_i and much slower
module tick_source #(
  parameter int WDIV = timer_pkg::WATCH_DIV
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n,
  input  wire logic watch_clk,
  tick_if.src       ticks
);
  logic [4:0] pre_r, pre_nxt;
  logic [1:0] wcnt_r, wcnt_nxt;
  logic       wprev_r;
  logic       d32_r, d16_r, d4_r, w4_r;
  logic       d32_nxt, d16_nxt, d4_nxt, w4_nxt;
  logic       wrise;

  always_comb begin
    wrise    = watch_clk & ~wprev_r;
    pre_nxt  = pre_r + 5'h01;
    d32_nxt  = (pre_r == 5'h1f);
    d16_nxt  = (pre_r[3:0] == 4'hf);
    d4_nxt   = (pre_r[1:0] == 2'h3);
    wcnt_nxt = wcnt_r;
    w4_nxt   = 1'b0;
    if (wrise) begin
      if (wcnt_r == 2'(WDIV - 1)) begin
        wcnt_nxt = 2'h0;
        w4_nxt   = 1'b1;
      end else begin
        wcnt_nxt = wcnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_r   <= 5'h00;
      wcnt_r  <= 2'h0;
      wprev_r <= 1'b0;
      d32_r   <= 1'b0;
      d16_r   <= 1'b0;
      d4_r    <= 1'b0;
      w4_r    <= 1'b0;
    end else begin
      pre_r   <= pre_nxt;
      wcnt_r  <= wcnt_nxt;
      wprev_r <= watch_clk;
      d32_r   <= d32_nxt;
      d16_r   <= d16_nxt;
      d4_r    <= d4_nxt;
      w4_r    <= w4_nxt;
    end
  end

  assign ticks.div32 = d32_r;
  assign ticks.div16 = d16_r;
  assign ticks.div4  = d4_r;
  assign ticks.wdiv4 = w4_r;
endmodule : tick_source

// >>> design/event_edge.sv
// edge detector on the external event pin, polarity chosen by edge select
// assumes the pin is synchronous to sys_clk_i
module event_edge (
  input  wire logic sys_clk_i,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic rising_sel,
  output logic      edge_pulse
);
  logic prev_r;

  always_comb begin
    edge_pulse = rising_sel ? (pin & ~prev_r) : (~pin & prev_r);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin;
    end
  end
endmodule : event_edge

// >>> design/dual_timer_control_status.sv
// 16-bit compare-match timer, or two 8-bit timers, with mode and flag registers
// assumes a plain register port: strobes one cycle, read data the cycle after
module dual_timer_control_status (
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       event_input_pin_i,
  input  wire logic       event_edge_select_i,
  input  wire logic       watch_clk_i,
  output logic            upper_toggle_pin_o,
  output logic            lower_toggle_pin_o,
  output logic            high_irq_o,
  output logic            low_irq_o
);
  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] arm_r, arm_nxt;
  logic [7:0] upper_r, upper_nxt;
  logic [7:0] lower_r, lower_nxt;
  logic [7:0] ucmp_r, ucmp_nxt;
  logic [7:0] lcmp_r, lcmp_nxt;
  logic       upin_r, upin_nxt;
  logic       lpin_r, lpin_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       hirq_r, hirq_nxt;
  logic       lirq_r, lirq_nxt;
  logic       wide_mode, ev_pulse;
  logic       low_tick, high_tick, low_eq, up_eq, wide_eq;
  logic       low_match_ev, high_match_ev, wide_clr, low_clr, high_clr;
  logic       low_wrap, high_wrap;
  logic [7:0] set_bits, clr_bits;

  tick_if ticks ();

  tick_source u_ticks (
    .sys_clk_i (sys_clk_i),
    .rst_n     (rst_n),
    .watch_clk (watch_clk_i),
    .ticks     (ticks.src)
  );

  event_edge u_edge (
    .sys_clk_i  (sys_clk_i),
    .rst_n      (rst_n),
    .pin        (event_input_pin_i),
    .rising_sel (event_edge_select_i),
    .edge_pulse (ev_pulse)
  );

  // internal clock source for one counter lane
  function automatic logic sel_tick(input logic [2:0] sel, input logic d32,
                                    input logic d16, input logic d4, input logic w4);
    unique case (sel)
      timer_pkg::SEL_DIV32: sel_tick = d32;
      timer_pkg::SEL_DIV16: sel_tick = d16;
      timer_pkg::SEL_DIV4:  sel_tick = d4;
      timer_pkg::SEL_WDIV4: sel_tick = w4;
      default:              sel_tick = 1'b0;
    endcase
  endfunction : sel_tick

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // counting datapath
  always_comb begin
    wide_mode = ~mode_r[timer_pkg::HIGH_SEL_MSB];
    low_tick  = mode_r[timer_pkg::LOW_SEL_MSB]
              ? sel_tick(mode_r[timer_pkg::LOW_SEL_MSB:timer_pkg::LOW_SEL_LSB],
                         ticks.div32, ticks.div16, ticks.div4, ticks.wdiv4)
              : ev_pulse;
    low_eq    = (lower_r == lcmp_r);
    up_eq     = (upper_r == ucmp_r);
    wide_eq   = low_eq & up_eq;
    low_match_ev = low_tick & (wide_mode ? wide_eq : low_eq);
    wide_clr  = wide_mode & low_match_ev & flags_r[timer_pkg::HIGH_CLR_BIT];
    low_clr   = ~wide_mode & low_match_ev & flags_r[timer_pkg::LOW_CLR_BIT];
    low_wrap  = low_tick & (lower_r == 8'hff) & ~wide_clr & ~low_clr;
    high_tick = wide_mode ? low_wrap
              : sel_tick(mode_r[timer_pkg::HIGH_SEL_MSB:timer_pkg::HIGH_SEL_LSB],
                         ticks.div32, ticks.div16, ticks.div4, ticks.wdiv4);
    high_match_ev = wide_mode ? low_match_ev : (high_tick & up_eq);
    high_clr  = wide_mode ? wide_clr
              : (high_match_ev & flags_r[timer_pkg::HIGH_CLR_BIT]);
    high_wrap = high_tick & (upper_r == 8'hff) & ~high_clr;
    lower_nxt = lower_r;
    upper_nxt = upper_r;
    if (wide_clr || low_clr) begin
      lower_nxt = timer_pkg::COUNT_RESET;
    end else if (low_tick) begin
      lower_nxt = lower_r + 8'h01;
    end
    if (high_clr) begin
      upper_nxt = timer_pkg::COUNT_RESET;
    end else if (high_tick) begin
      upper_nxt = upper_r + 8'h01;
    end
    // a software load of a counter wins over counting
    if (wr_i && addr_i == timer_pkg::IDX_LOWER) begin
      lower_nxt = wdata_i;
    end
    if (wr_i && addr_i == timer_pkg::IDX_UPPER) begin
      upper_nxt = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lower_r <= timer_pkg::COUNT_RESET;
      upper_r <= timer_pkg::COUNT_RESET;
    end else begin
      lower_r <= lower_nxt;
      upper_r <= upper_nxt;
    end
  end

  // registers, flags, pins and requests
  always_comb begin
    set_bits = 8'h00;
    set_bits[timer_pkg::HIGH_OVF_BIT]   = high_wrap;
    set_bits[timer_pkg::HIGH_MATCH_BIT] = high_match_ev;
    set_bits[timer_pkg::LOW_OVF_BIT]    = ~wide_mode & low_wrap;
    set_bits[timer_pkg::LOW_MATCH_BIT]  = ~wide_mode & low_match_ev;
    mode_nxt  = mode_r;
    flags_nxt = flags_r;
    arm_nxt   = arm_r;
    ucmp_nxt  = ucmp_r;
    lcmp_nxt  = lcmp_r;
    clr_bits  = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        timer_pkg::IDX_MODE:      mode_nxt = wdata_i;
        timer_pkg::IDX_UPPER_CMP: ucmp_nxt = wdata_i;
        timer_pkg::IDX_LOWER_CMP: lcmp_nxt = wdata_i;
        timer_pkg::IDX_FLAGS: begin
          clr_bits  = ~wdata_i & arm_r & timer_pkg::FLAG_MASK;
          flags_nxt = (flags_r & timer_pkg::FLAG_MASK) | (wdata_i & ~timer_pkg::FLAG_MASK);
          arm_nxt   = 8'h00;
        end
        default: ;
      endcase
    end
    flags_nxt = (flags_nxt & ~clr_bits) | set_bits;
    if (rd_i && addr_i == timer_pkg::IDX_FLAGS) begin
      arm_nxt = flags_r & timer_pkg::FLAG_MASK;
    end
    rdata_nxt = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        timer_pkg::IDX_FLAGS:     rdata_nxt = flags_r;
        timer_pkg::IDX_UPPER:     rdata_nxt = upper_r;
        timer_pkg::IDX_LOWER:     rdata_nxt = lower_r;
        timer_pkg::IDX_UPPER_CMP: rdata_nxt = ucmp_r;
        timer_pkg::IDX_LOWER_CMP: rdata_nxt = lcmp_r;
        default:                  rdata_nxt = 8'h00;
      endcase
    end
    upin_nxt = upin_r ^ high_match_ev;
    lpin_nxt = lpin_r ^ (~wide_mode & low_match_ev);
    // a level write beats a simultaneous toggle
    if (wr_i && addr_i == timer_pkg::IDX_MODE) begin
      upin_nxt = wdata_i[timer_pkg::HIGH_LEVEL_BIT];
      lpin_nxt = wdata_i[timer_pkg::LOW_LEVEL_BIT];
    end
    hirq_nxt = high_match_ev | (high_wrap & flags_r[timer_pkg::HIGH_OVIE_BIT]);
    lirq_nxt = ~wide_mode
             & (low_match_ev | (low_wrap & flags_r[timer_pkg::LOW_OVIE_BIT]));
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_r  <= timer_pkg::MODE_RESET;
      flags_r <= timer_pkg::FLAGS_RESET;
      arm_r   <= 8'h00;
      ucmp_r  <= timer_pkg::CMP_RESET;
      lcmp_r  <= timer_pkg::CMP_RESET;
      upin_r  <= 1'b0;
      lpin_r  <= 1'b0;
      rdata_r <= 8'h00;
      hirq_r  <= 1'b0;
      lirq_r  <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      flags_r <= flags_nxt;
      arm_r   <= arm_nxt;
      ucmp_r  <= ucmp_nxt;
      lcmp_r  <= lcmp_nxt;
      upin_r  <= upin_nxt;
      lpin_r  <= lpin_nxt;
      rdata_r <= rdata_nxt;
      hirq_r  <= hirq_nxt;
      lirq_r  <= lirq_nxt;
    end
  end

  assign rdata_o            = rdata_r;
  assign upper_toggle_pin_o = upin_r;
  assign lower_toggle_pin_o = lpin_r;
  assign high_irq_o         = hirq_r;
  assign low_irq_o          = lirq_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  a_upper_level_write: assert property (
    (wr_i && addr_i == timer_pkg::IDX_MODE) |=> (upper_toggle_pin_o == $past(wdata_i[7])))
    else $error("upper toggle pin does not follow written level");
  a_lower_level_write: assert property (
    (wr_i && addr_i == timer_pkg::IDX_MODE) |=> (lower_toggle_pin_o == $past(wdata_i[3])))
    else $error("lower toggle pin does not follow written level");
  a_wide_carry: assert property (
    (!mode_r[6] && low_tick && lower_r == 8'hff && !wide_clr && !wr_i)
    |=> (upper_r == $past(upper_r) + 8'h01) && (lower_r == 8'h00))
    else $error("16-bit carry into upper counter missing");
  a_high_ovf_set: assert property (
    (high_tick && upper_r == 8'hff && !high_clr) |=> flags_r[7])
    else $error("high overflow flag not set on wrap");
  a_flag_no_set1: assert property (
    (wr_i && addr_i == timer_pkg::IDX_FLAGS && !flags_r[6] && !high_match_ev) |=> !flags_r[6])
    else $error("writing the flags register set a match flag");
  a_high_match_set: assert property (
    (!mode_r[6] && low_tick && upper_r == ucmp_r && lower_r == lcmp_r)
    |=> flags_r[6] ##1 (hirq_r == 1'b0 || flags_r[6]))
    else $error("high match flag not set on match");
  a_low_ovf_set: assert property (
    (mode_r[6] && low_tick && lower_r == 8'hff && !low_clr) |=> flags_r[3])
    else $error("low overflow flag not set on wrap");
  a_set_beats_clear: assert property (
    (wr_i && addr_i == timer_pkg::IDX_FLAGS && set_bits[2]) |=> flags_r[2])
    else $error("hardware set lost to a software clear");
  a_upper_div_tick: assert property (
    (mode_r[6:4] == timer_pkg::SEL_DIV4 && ticks.div4 && !high_clr && !wr_i)
    |=> (upper_r == $past(upper_r) + 8'h01))
    else $error("split upper counter missed a divided tick");
  a_event_count: assert property (
    (!mode_r[2] && ev_pulse && !low_clr && !wide_clr && !wr_i)
    |=> (lower_r == $past(lower_r) + 8'h01))
    else $error("lower counter missed an event edge");
  a_lower_div_tick: assert property (
    (mode_r[2:0] == timer_pkg::SEL_DIV32 && ticks.div32 && !low_clr && !wide_clr && !wr_i)
    |=> (lower_r == $past(lower_r) + 8'h01))
    else $error("lower counter missed a divided tick");
  a_high_irq_gate: assert property (
    (high_wrap && !flags_r[5] && !high_match_ev) |=> !high_irq_o)
    else $error("upper overflow request while disabled");
  a_wide_clear: assert property (
    (wide_clr && !wr_i) |=> (upper_r == 8'h00) && (lower_r == 8'h00))
    else $error("16-bit counter not cleared on match");
  a_upper_clear: assert property (
    (mode_r[6] && high_clr && !wr_i) |=> (upper_r == 8'h00))
    else $error("upper counter not cleared on match");
  a_low_match_set: assert property (
    (mode_r[6] && low_tick && lower_r == lcmp_r) |=> flags_r[2])
    else $error("low match flag not set on match");
  a_low_irq_gate: assert property (
    (mode_r[6] && low_wrap && !flags_r[1] && !low_match_ev) |=> !low_irq_o)
    else $error("lower overflow request while disabled");
  a_low_clear: assert property (
    (mode_r[6] && low_match_ev && flags_r[0] && !wr_i) |=> (lower_r == 8'h00))
    else $error("lower counter not cleared on match");
  a_match_on_leave: assert property (
    (mode_r[6] && lower_r == lcmp_r && !low_tick && !wr_i)
    |=> (flags_r[2] == $past(flags_r[2])))
    else $error("low match flag changed without a count tick");
endmodule : dual_timer_control_status

// >>> bench/dual_timer_control_status_bench.sv
// self-checking bench for the dual timer mode and flag registers
// assumes the design files are compiled first; bench drives every port itself
module dual_timer_control_status_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic       sys_clk_i           = 1'b0;
  logic       resetn_i            = 1'b0;
  logic [2:0] addr_i              = 3'h0;
  logic [7:0] wdata_i             = 8'h00;
  logic       wr_i                = 1'b0;
  logic       rd_i                = 1'b0;
  logic       event_input_pin_i   = 1'b0;
  logic       event_edge_select_i = 1'b1;
  logic       watch_clk_i         = 1'b0;
  logic [7:0] rdata_o;
  logic       upper_toggle_pin_o;
  logic       lower_toggle_pin_o;
  logic       high_irq_o;
  logic       low_irq_o;
  logic [1:0] watch_div           = 2'h0;
  int         error_cnt           = 0;
  int         checks_done         = 0;
  int         cycle_cnt           = 0;
  int         high_pulses         = 0;
  int         low_pulses          = 0;

  dual_timer_control_status u_dual_timer_control_status (
    .sys_clk_i           (sys_clk_i),
    .resetn_i            (resetn_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .rdata_o             (rdata_o),
    .event_input_pin_i   (event_input_pin_i),
    .event_edge_select_i (event_edge_select_i),
    .watch_clk_i         (watch_clk_i),
    .upper_toggle_pin_o  (upper_toggle_pin_o),
    .lower_toggle_pin_o  (lower_toggle_pin_o),
    .high_irq_o          (high_irq_o),
    .low_irq_o           (low_irq_o)
  );

  always #50 sys_clk_i = ~sys_clk_i;

  // watch clock has a period of four system clocks; interrupt pulses are tallied
  always @(posedge sys_clk_i) begin
    watch_div <= watch_div + 2'h1;
    watch_clk_i <= watch_div[1];
    if (high_irq_o === 1'b1) high_pulses++;
    if (low_irq_o === 1'b1) low_pulses++;
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i) begin
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
    end
    @(posedge sys_clk_i) wr_i <= 1'b0;
  endtask : wr

  // read data is sampled in the one cycle after the read edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_i) begin
      rd_i <= 1'b1;
      addr_i <= a;
    end
    @(posedge sys_clk_i) rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk8(v, exp);
  endtask : rdchk

  // low flag nibble only, the upper counter may run meanwhile
  task automatic lowflags(input logic [7:0] exp);
    logic [7:0] v;
    rd(3'h1, v);
    chk8(v & 8'h0f, exp);
  endtask : lowflags

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge sys_clk_i) event_input_pin_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      event_input_pin_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
    end
  endtask : pulse

  task automatic t_reset();
    logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
    for (int i = 0; i < 6; i++) rdchk(3'(i), exp[i]);
    chk1(upper_toggle_pin_o, 1'b0);
    wr(3'h6, 8'h5a);
    rdchk(3'h6, 8'h00);
  endtask : t_reset

  task automatic t_levels();
    wr(3'h0, 8'h80);
    repeat (2) @(posedge sys_clk_i);
    #1 chk1(upper_toggle_pin_o, 1'b1);
    chk1(lower_toggle_pin_o, 1'b0);
    wr(3'h0, 8'h48);
    repeat (2) @(posedge sys_clk_i);
    #1 chk1(upper_toggle_pin_o, 1'b0);
    chk1(lower_toggle_pin_o, 1'b1);
    rdchk(3'h0, 8'h00);
  endtask : t_levels

  // counts over 64 cycles for /32, /16, /4 and watch /4 on both counters
  task automatic t_prescale();
    logic [7:0] exp [4] = '{8'h02, 8'h04, 8'h10, 8'h04};
    logic [7:0] u0, l0, u1, l1;
    for (int s = 4; s < 8; s++) begin
      wr(3'h0, {1'b0, 3'(s), 1'b0, 3'(s)});
      rd(3'h2, u0);
      rd(3'h3, l0);
      repeat (60) @(posedge sys_clk_i);
      rd(3'h2, u1);
      rd(3'h3, l1);
      chk8(u1 - u0, exp[s-4]);
      chk8(l1 - l0, exp[s-4]);
    end
  endtask : t_prescale

  task automatic t_events();
    logic [7:0] v;
    int         l0;
    wr(3'h0, 8'h40);
    wr(3'h5, 8'h02);
    wr(3'h3, 8'hfe);
    wr(3'h1, 8'h00);
    l0 = low_pulses;
    pulse(2);
    lowflags(8'h08);
    chk8(8'(low_pulses - l0), 8'h00);
    pulse(2);
    lowflags(8'h08);
    pulse(1);
    lowflags(8'h0c);
    wr(3'h1, 8'hcc);
    lowflags(8'h0c);
    wr(3'h1, 8'hcc);
    wr(3'h1, 8'h00);
    lowflags(8'h0c);
    wr(3'h1, 8'h00);
    lowflags(8'h00);
    wr(3'h1, 8'h03);
    wr(3'h3, 8'hff);
    l0 = low_pulses;
    pulse(1);
    chk8(8'(low_pulses - l0), 8'h01);
    lowflags(8'h0b);
    pulse(3);
    rdchk(3'h3, 8'h00);
    lowflags(8'h0f);
    @(posedge sys_clk_i) event_edge_select_i <= 1'b0;
    @(posedge sys_clk_i) event_input_pin_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rdchk(3'h3, 8'h00);
    @(posedge sys_clk_i) event_input_pin_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rdchk(3'h3, 8'h01);
    @(posedge sys_clk_i) event_edge_select_i <= 1'b1;
    // match tick and an armed clear of the match flag land on one edge
    pulse(1);
    rd(3'h1, v);
    @(posedge sys_clk_i) begin
      event_input_pin_i <= 1'b1;
      wr_i <= 1'b1;
      addr_i <= 3'h1;
      wdata_i <= 8'h03;
    end
    @(posedge sys_clk_i) wr_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    event_input_pin_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    lowflags(8'h07);
  endtask : t_events

  task automatic t_upper();
    logic [7:0] v;
    int         h0;
    wr(3'h0, 8'h60);
    wr(3'h4, 8'h80);
    wr(3'h1, 8'h00);
    h0 = high_pulses;
    wr(3'h2, 8'hff);
    repeat (8) @(posedge sys_clk_i);
    chk8(8'(high_pulses - h0), 8'h00);
    rd(3'h1, v);
    chk8(v & 8'h80, 8'h80);
    wr(3'h1, 8'h20);
    h0 = high_pulses;
    wr(3'h2, 8'hff);
    repeat (8) @(posedge sys_clk_i);
    chk8(8'(high_pulses - h0), 8'h01);
    wr(3'h4, 8'h03);
    wr(3'h3, 8'h50);
    wr(3'h1, 8'h10);
    wr(3'h2, 8'h00);
    repeat (40) @(posedge sys_clk_i);
    rd(3'h2, v);
    chk1(v <= 8'h03, 1'b1);
    rdchk(3'h3, 8'h50);
  endtask : t_upper

  task automatic t_wide();
    logic [7:0] v;
    wr(3'h0, 8'h80);
    wr(3'h4, 8'h01);
    wr(3'h5, 8'h01);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'hff);
    rd(3'h1, v);
    wr(3'h1, 8'h10);
    pulse(1);
    rdchk(3'h2, 8'h01);
    rdchk(3'h3, 8'h00);
    pulse(1);
    #1 chk1(upper_toggle_pin_o, 1'b1);
    pulse(1);
    rdchk(3'h2, 8'h00);
    rdchk(3'h3, 8'h00);
    rd(3'h1, v);
    chk8(v & 8'h4f, 8'h40);
    chk1(upper_toggle_pin_o, 1'b0);
  endtask : t_wide

  initial begin
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_reset();
    t_levels();
    t_prescale();
    t_events();
    t_upper();
    t_wide();
    @(posedge sys_clk_i) resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rdchk(3'h1, 8'h00);
    chk1(upper_toggle_pin_o, 1'b0);
    summarize();
  end
endmodule : dual_timer_control_status_bench
